/* dcr_pkg.sv */
// Shared constants and types for the core run control block.
`default_nettype none

package dcr_pkg;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [15:0] SUSPEND_OFS = 16'hF400;
	localparam logic [15:0] TRIGGER_OFS = 16'hF402;
	localparam logic [15:0] HALT_OFS    = 16'hF403;
	localparam logic [15:0] ENTRY_OFS   = 16'hF404;
	localparam logic [15:0] STATUS_OFS  = 16'hF405;

	// ------------------------------------------------------------------
	// Field positions and values after reset
	// ------------------------------------------------------------------
	localparam int          CTRL_BIT      = 0;
	localparam logic [15:0] SUSPEND_RST   = 16'h0000;
	localparam logic [15:0] TRIGGER_RST   = 16'h0000;
	localparam logic [15:0] HALT_RST      = 16'h0000;
	localparam logic [15:0] ENTRY_RST     = 16'h0000;
	localparam logic [15:0] READ_ZERO     = 16'h0000;

	// ------------------------------------------------------------------
	// Status codes shown in the status register
	// ------------------------------------------------------------------
	localparam logic [15:0] STAT_STOPPED   = 16'h0000;
	localparam logic [15:0] STAT_INIT      = 16'h0001;
	localparam logic [15:0] STAT_RUN       = 16'h0002;
	localparam logic [15:0] STAT_DRAIN     = 16'h0003;
	localparam logic [15:0] STAT_SUSPENDED = 16'h0004;
	localparam logic [15:0] STAT_HALTED    = 16'h0005;

	// ------------------------------------------------------------------
	// Core sequencing states
	// ------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ST_STOPPED,
		ST_INIT,
		ST_RUN,
		ST_DRAIN,
		ST_SUSPENDED,
		ST_HALTED
	} dcr_state_type;

endpackage

`default_nettype wire

/* dcr_irq_gate.sv */
// Interrupt gate that blocks new requests and reports when service drains.
`timescale 1ns/1ps
`default_nettype none

module dcr_irq_gate
(
	// Clock and reset.
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	// Control from the sequencer.
	input  wire logic irq_enable_i,
	// Core interrupt signals.
	input  wire logic irq_req_i,
	input  wire logic irq_busy_i,
	// Gated results.
	output logic      irq_take_o,
	output logic      drained_o
);

	typedef struct packed
	{
		logic drained;
	} dcr_gate_type;

	dcr_gate_type r;
	dcr_gate_type next_r;

	// A request reaches the core only while interrupts are enabled.
	assign irq_take_o = irq_req_i & irq_enable_i;
	assign drained_o  = r.drained;

	// Drained once enable is off and no service routine is still active.
	always_comb
	begin
		next_r         = r;
		next_r.drained = ~irq_enable_i & ~irq_busy_i;
	end

	// State register.
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			r <= '0;
		else
			r <= next_r;
	end

endmodule

`default_nettype wire

/* dcr_run_ctrl.sv */
// Run, suspend and halt control for the audio DSP core.
// Function
// RQ1: Suspend write disables interrupts, drains service, then core runs no-ops.
// RQ2: Halt stops the core fully; no processing continues.
// RQ3: Host halts the core before overwriting program memory.
// RQ4: Parameter-only updates may keep the core merely suspended.
// RQ5: Host waits one sample or block after suspend before memory access.
// RQ6: Host writes one to halt register before loading a new program.
// RQ7: Host loads program image by block write from program base.
// RQ8: Host rewrites first data bank by block write from zero.
// RQ9: Host rewrites second data bank at the image's own start.
// RQ10: Host writes the entry point after a new program download.
// RQ11: Halt release by writing zero; starts are refused while halted.
// RQ12: Core starts on a low-to-high change of the run trigger bit.
// RQ13: Host waits for the init routine before releasing suspend.
// RQ14: Clearing suspend re-enables interrupts and resumes normal execution.
// RQ15: Host keeps the core stopped while memories are rewritten.
// RQ16: Control registers are sixteen bits wide; only bit zero acts.
`timescale 1ns/1ps
`default_nettype none

module dcr_run_ctrl
(
	// Clock and reset.
	input  wire logic        ref_clk_i,
	input  wire logic        rst_n_i,
	// Control port register access, same clock.
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [15:0] reg_addr_i,
	input  wire logic [15:0] reg_wdata_i,
	output logic      [15:0] reg_rdata_o,
	output logic             reg_rvalid_o,
	// Core interrupt signals.
	input  wire logic        irq_req_i,
	input  wire logic        irq_busy_i,
	output logic             irq_take_o,
	// Core execution control.
	output logic             core_exec_o,
	output logic             core_nop_o,
	output logic             core_clk_en_o,
	output logic             core_start_o,
	output logic      [15:0] core_entry_o
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------

	typedef struct packed
	{
		logic [15:0]           suspend;
		logic [15:0]           trigger;
		logic [15:0]           halt;
		logic [15:0]           entry;
		dcr_pkg::dcr_state_type state;
		logic [15:0]           rdata;
		logic                  rvalid;
		logic                  start;
		logic                  exec;
		logic                  nop;
		logic                  clk_en;
		logic                  irq_en;
	} dcr_ctrl_type;

	dcr_ctrl_type r;
	dcr_ctrl_type next_r;
	logic         drained;

	// Maps a sequencing state onto its readable status code.
	function automatic logic [15:0] status_code(
		input dcr_pkg::dcr_state_type s);
		case (s)
			dcr_pkg::ST_STOPPED:   status_code = dcr_pkg::STAT_STOPPED;
			dcr_pkg::ST_INIT:      status_code = dcr_pkg::STAT_INIT;
			dcr_pkg::ST_RUN:       status_code = dcr_pkg::STAT_RUN;
			dcr_pkg::ST_DRAIN:     status_code = dcr_pkg::STAT_DRAIN;
			dcr_pkg::ST_SUSPENDED: status_code = dcr_pkg::STAT_SUSPENDED;
			dcr_pkg::ST_HALTED:    status_code = dcr_pkg::STAT_HALTED;
			default:               status_code = dcr_pkg::STAT_STOPPED;
		endcase
	endfunction

	// Tells whether a write hits the given register this cycle.
	function automatic logic hit(
		input logic        wr,
		input logic [15:0] addr,
		input logic [15:0] ofs);
		hit = wr & (addr == ofs);
	endfunction

	// ------------------------------------------------------------------
	// Interrupt gate
	// ------------------------------------------------------------------

	// Blocks requests while suspended and reports when service is done.
	dcr_irq_gate u_gate
	(
		.ref_clk_i    (ref_clk_i),
		.rst_n_i      (rst_n_i),
		.irq_enable_i (r.irq_en),
		.irq_req_i    (irq_req_i),
		.irq_busy_i   (irq_busy_i),
		.irq_take_o   (irq_take_o),
		.drained_o    (drained)
	);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------

	// Register writes, readback and the run sequencer.
	always_comb
	begin
		logic susp_bit;
		logic halt_bit;
		logic trig_rise;
		susp_bit     = 1'b0;
		halt_bit     = 1'b0;
		trig_rise    = 1'b0;
		next_r       = r;
		next_r.start = 1'b0;
		// RQ16: full word stored
		if (hit(reg_wr_i, reg_addr_i, dcr_pkg::SUSPEND_OFS))
			next_r.suspend = reg_wdata_i;
		if (hit(reg_wr_i, reg_addr_i, dcr_pkg::TRIGGER_OFS))
			next_r.trigger = reg_wdata_i;
		if (hit(reg_wr_i, reg_addr_i, dcr_pkg::HALT_OFS))
			next_r.halt = reg_wdata_i;
		if (hit(reg_wr_i, reg_addr_i, dcr_pkg::ENTRY_OFS))
			next_r.entry = reg_wdata_i;

		// RQ16: only bit zero
		susp_bit  = next_r.suspend[dcr_pkg::CTRL_BIT];
		halt_bit  = next_r.halt[dcr_pkg::CTRL_BIT];
		// RQ12: low-to-high detect
		trig_rise = next_r.trigger[dcr_pkg::CTRL_BIT]
			& ~r.trigger[dcr_pkg::CTRL_BIT];

		// Registered readback; unmapped addresses read as zero.
		next_r.rvalid = reg_rd_i;
		if (reg_rd_i)
		begin
			case (reg_addr_i)
				dcr_pkg::SUSPEND_OFS: next_r.rdata = r.suspend;
				dcr_pkg::TRIGGER_OFS: next_r.rdata = r.trigger;
				dcr_pkg::HALT_OFS:    next_r.rdata = r.halt;
				dcr_pkg::ENTRY_OFS:   next_r.rdata = r.entry;
				dcr_pkg::STATUS_OFS:  next_r.rdata = status_code(r.state);
				default:              next_r.rdata = dcr_pkg::READ_ZERO;
			endcase
		end

		// RQ2: halt overrides all
		if (halt_bit)
			next_r.state = dcr_pkg::ST_HALTED;
		else
		begin
			case (r.state)
				// RQ11: release only
				dcr_pkg::ST_HALTED:
					next_r.state = dcr_pkg::ST_STOPPED;
				// RQ12: start on edge
				dcr_pkg::ST_STOPPED:
					if (trig_rise)
					begin
						next_r.start = 1'b1;
						next_r.state = susp_bit ? dcr_pkg::ST_INIT
							: dcr_pkg::ST_RUN;
					end
				// Init routine runs with interrupts held off.
				dcr_pkg::ST_INIT:
					if (!susp_bit)
						next_r.state = dcr_pkg::ST_RUN;
				// RQ1: begin draining
				dcr_pkg::ST_RUN:
					if (susp_bit)
						next_r.state = dcr_pkg::ST_DRAIN;
				// RQ1: wait for service
				dcr_pkg::ST_DRAIN:
					if (!susp_bit)
						next_r.state = dcr_pkg::ST_RUN;
					else if (drained)
						next_r.state = dcr_pkg::ST_SUSPENDED;
				// RQ14: resume on clear
				dcr_pkg::ST_SUSPENDED:
					if (!susp_bit)
						next_r.state = dcr_pkg::ST_RUN;
				default:
					next_r.state = dcr_pkg::ST_STOPPED;
			endcase
		end

		// Core controls follow the next state so they align with it.
		next_r.clk_en = (next_r.state != dcr_pkg::ST_HALTED);
		next_r.exec   = (next_r.state == dcr_pkg::ST_RUN)
			| (next_r.state == dcr_pkg::ST_INIT)
			| (next_r.state == dcr_pkg::ST_DRAIN);
		// RQ1: no-ops when suspended
		next_r.nop    = (next_r.state == dcr_pkg::ST_SUSPENDED);
		// RQ14: interrupts re-enabled
		next_r.irq_en = (next_r.state == dcr_pkg::ST_RUN);
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------

	// All state updates on every edge; reset gives defined values.
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			r         <= '0;
			r.suspend <= dcr_pkg::SUSPEND_RST;
			r.trigger <= dcr_pkg::TRIGGER_RST;
			r.halt    <= dcr_pkg::HALT_RST;
			r.entry   <= dcr_pkg::ENTRY_RST;
			r.state   <= dcr_pkg::ST_STOPPED;
			r.clk_en  <= 1'b1;
		end
		else
			r <= next_r;
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------

	// Every output except irq_take_o comes straight from a flip-flop.
	assign reg_rdata_o   = r.rdata;
	assign reg_rvalid_o  = r.rvalid;
	assign core_exec_o   = r.exec;
	assign core_nop_o    = r.nop;
	assign core_clk_en_o = r.clk_en;
	assign core_start_o  = r.start;
	assign core_entry_o  = r.entry;

endmodule

`default_nettype wire

/* dcr_run_ctrl_chk.sv */
// Port checker for the core run control block.
`timescale 1ns/1ps
`default_nettype none

module dcr_chk
(
	// Clock and reset.
	input wire logic        ref_clk_i,
	input wire logic        rst_n_i,
	// Register access.
	input wire logic        reg_wr_i,
	input wire logic        reg_rd_i,
	input wire logic [15:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [15:0] reg_rdata_o,
	input wire logic        reg_rvalid_o,
	// Interrupts and core control.
	input wire logic        irq_req_i,
	input wire logic        irq_busy_i,
	input wire logic        irq_take_o,
	input wire logic        core_exec_o,
	input wire logic        core_nop_o,
	input wire logic        core_clk_en_o,
	input wire logic        core_start_o,
	input wire logic [15:0] core_entry_o
);
	logic wr_sus;
	logic wr_halt;
	logic wr_trig;
	logic trig_ok;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Decode of writes to the three control registers.
	assign wr_sus  = reg_wr_i && reg_addr_i == dcr_pkg::SUSPEND_OFS;
	assign wr_halt = reg_wr_i && reg_addr_i == dcr_pkg::HALT_OFS;
	assign wr_trig = reg_wr_i && reg_addr_i == dcr_pkg::TRIGGER_OFS;
	// A trigger write with bit zero set while the core clock still runs.
	assign trig_ok = wr_trig && reg_wdata_i[0] && core_clk_en_o;

	// --------------------------------------------------------------
	// Assertions on the core control outputs
	// --------------------------------------------------------------
	a_suspend_irq_off: assert property (wr_sus && reg_wdata_i[0] |=>
		!irq_take_o) else $error("irq taken after suspend");
	a_nop_only: assert property (core_nop_o |->
		!core_exec_o && !irq_take_o && core_clk_en_o) else $error("nop mix");
	a_halt_stop: assert property (wr_halt && reg_wdata_i[0] |=>
		!core_clk_en_o && !core_exec_o) else $error("halt not taken");
	a_halt_idle: assert property (!core_clk_en_o |->
		!core_exec_o && !core_nop_o && !irq_take_o) else $error("halt busy");
	a_start_cause: assert property (core_start_o |->
		$past(trig_ok))
		else $error("start without trigger");
	a_start_once: assert property (core_start_o |=>
		!core_start_o) else $error("start too long");
	a_start_exec: assert property (core_start_o |->
		core_exec_o) else $error("start without exec");
	a_resume_irq: assert property (wr_sus && !reg_wdata_i[0]
		&& core_exec_o |=> irq_take_o == irq_req_i) else $error("no resume");
	a_halt_bit_zero: assert property (wr_halt && !reg_wdata_i[0]
		&& core_clk_en_o |=> core_clk_en_o) else $error("upper bit acted");
endmodule

bind dcr_run_ctrl dcr_chk chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
	.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
	.reg_rvalid_o(reg_rvalid_o), .irq_req_i(irq_req_i),
	.irq_busy_i(irq_busy_i), .irq_take_o(irq_take_o),
	.core_exec_o(core_exec_o), .core_nop_o(core_nop_o),
	.core_clk_en_o(core_clk_en_o), .core_start_o(core_start_o),
	.core_entry_o(core_entry_o));

`default_nettype wire

/* dcr_host.sv */
// Host model that writes and reads register words on the control port.
`timescale 1ns/1ps
`default_nettype none

module dcr_host
(
	// Clock.
	input wire logic        ref_clk_i,
	// Read answer from the device.
	input wire logic [15:0] rdata_i,
	input wire logic        rvalid_i,
	// Register access towards the device.
	output var logic        wr_o = 1'b0,
	output var logic        rd_o = 1'b0,
	output var logic [15:0] addr_o = 16'h0000,
	output var logic [15:0] wdata_o = 16'h0000
);
	// One whole word per access; released lines show the inverse value.
	// whole words
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(negedge ref_clk_i);
		wr_o = 1'b1;
		addr_o = a;
		wdata_o = d;
		@(negedge ref_clk_i);
		wr_o = 1'b0;
		addr_o = ~a;
		wdata_o = ~d;
	endtask

	// Read returns unknown when no valid answer came one cycle later.
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(negedge ref_clk_i);
		rd_o = 1'b1;
		addr_o = a;
		@(negedge ref_clk_i);
		rd_o = 1'b0;
		addr_o = ~a;
		d = rvalid_i ? rdata_i : 16'hxxxx;
	endtask
endmodule

`default_nettype wire

/* tb_dcr_run_ctrl.sv */
// Self-checking testbench for the core run control block.
`timescale 1ns/1ps
`default_nettype none

module tb_dcr_run_ctrl;
	localparam int SAMPLE_CYC = 8;
	localparam int INIT_CYC = 10;
	localparam logic [15:0] PROG_BASE = 16'hC000;
	localparam logic [15:0] DM0_BASE = 16'h0000;
	logic [15:0] dm1;
	logic        ref_clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        irq_req_i = 1'b0;
	logic        irq_busy_i = 1'b0;
	logic        wr, rd, rvalid, take, exec, nop, clk_en, start;
	logic [15:0] addr, wdata, rdata, entry, v, ent;
	logic [4:0]  fl;
	int          error_cnt = 0;
	int          num_checks = 0;

	// Clock generation and flag bundle.
	initial forever #10 ref_clk_i = ~ref_clk_i;
	assign fl = {clk_en, exec, nop, start, take};

	dcr_host HST (.ref_clk_i(ref_clk_i), .rdata_i(rdata), .rvalid_i(rvalid),
		.wr_o(wr), .rd_o(rd), .addr_o(addr), .wdata_o(wdata));
	dcr_run_ctrl DUT (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
		.irq_req_i(irq_req_i), .irq_busy_i(irq_busy_i), .irq_take_o(take),
		.core_exec_o(exec), .core_nop_o(nop), .core_clk_en_o(clk_en),
		.core_start_o(start), .core_entry_o(entry));

	// Compare tasks, expectation function and the closing task.
	task automatic chk16(input logic [15:0] g, e, input string m);
		num_checks++;
		if (g !== e)
		begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, m);
		end
	endtask

	task automatic chk_fl(input logic [4:0] e, input string m);
		chk16({11'h000, fl}, {11'h000, e}, m);
	endtask

	function automatic logic [15:0] exp_stat(input logic susp, idle);
		if (!susp)
			return dcr_pkg::STAT_RUN;
		return idle ? dcr_pkg::STAT_SUSPENDED : dcr_pkg::STAT_DRAIN;
	endfunction

	task automatic wait_stat(input logic [15:0] s);
		HST.rd(dcr_pkg::STATUS_OFS, v);
		for (int i = 0; i < 20 && v !== s; i++)
			HST.rd(dcr_pkg::STATUS_OFS, v);
		chk16(v, s, "status");
	endtask

	task automatic trig();
		HST.wr(dcr_pkg::TRIGGER_OFS, 16'h0000);
		HST.wr(dcr_pkg::TRIGGER_OFS, 16'h0001);
	endtask

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog against a hung handshake.
	initial
	begin
		#40000;
		error_cnt++;
		print_verdict();
	end

	// Main sequence: reset, start, suspend, halt, reload and resume.
	initial
	begin
		void'($urandom(34));
		ent = 16'($urandom);
		repeat (10) @(posedge ref_clk_i);
		@(negedge ref_clk_i);
		rst_n_i = 1'b1;
		chk_fl(5'b10000, "after reset");
		dm1 = 16'h6000 + 16'($urandom_range(0, 15));
		for (int i = 0; i < 6; i++)
		begin
			HST.rd(16'hF400 + 16'(i), v);
			chk16(v, dcr_pkg::READ_ZERO, "reset read");
		end
		HST.rd(16'hF406 + 16'($urandom_range(0, 9)), v);
		chk16(v, 16'h0000, "unmapped read");
		irq_req_i = 1'b1;
		repeat (4)
		begin
			HST.wr(dcr_pkg::HALT_OFS, 16'($urandom) & 16'hFFFE);
			chk_fl(5'b10000, "even halt word");
		end
		trig();
		chk_fl(5'b11011, "start");
		irq_busy_i = 1'b1;
		HST.wr(dcr_pkg::SUSPEND_OFS, 16'h0001);
		chk_fl(5'b11000, "drain");
		repeat ($urandom_range(2, 6)) @(negedge ref_clk_i);
		wait_stat(exp_stat(1'b1, 1'b0));
		irq_busy_i = 1'b0;
		wait_stat(exp_stat(1'b1, 1'b1));
		chk_fl(5'b10100, "no-op only");
		repeat (SAMPLE_CYC) @(negedge ref_clk_i);
		HST.wr(dcr_pkg::HALT_OFS, 16'h0001);
		chk_fl(5'b00000, "halted");
		for (int i = 0; i < 4; i++)
			HST.wr(PROG_BASE + 16'(i), 16'($urandom));
		HST.wr(DM0_BASE, 16'($urandom));
		HST.wr(dm1, 16'($urandom));
		chk_fl(5'b00000, "halted during load");
		trig();
		chk_fl(5'b00000, "start refused");
		HST.wr(dcr_pkg::ENTRY_OFS, ent);
		HST.rd(dcr_pkg::ENTRY_OFS, v);
		chk16(v, ent, "entry readback");
		HST.wr(dcr_pkg::HALT_OFS, 16'h0000);
		wait_stat(dcr_pkg::STAT_STOPPED);
		trig();
		chk_fl(5'b11010, "restart");
		chk16(entry, ent, "entry out");
		repeat (INIT_CYC) @(negedge ref_clk_i);
		HST.wr(dcr_pkg::SUSPEND_OFS, 16'h0000);
		chk_fl(5'b11001, "resume");
		wait_stat(exp_stat(1'b0, 1'b0));
		// drain cut short by a resume
		irq_busy_i = 1'b1;
		HST.wr(dcr_pkg::SUSPEND_OFS, 16'h0001);
		chk_fl(5'b11000, "drain again");
		HST.wr(dcr_pkg::SUSPEND_OFS, 16'h0000);
		chk_fl(5'b11001, "resume from drain");
		irq_busy_i = 1'b0;
		HST.wr(dcr_pkg::SUSPEND_OFS, 16'h0001);
		repeat (SAMPLE_CYC) @(negedge ref_clk_i);
		wait_stat(exp_stat(1'b1, 1'b1));
		for (int i = 0; i < 4; i++)
		begin
			HST.wr(DM0_BASE + 16'(i), 16'($urandom));
			HST.wr(dm1 + 16'(i), 16'($urandom));
		end
		chk_fl(5'b10100, "params under suspend");
		HST.wr(dcr_pkg::SUSPEND_OFS, 16'h0000);
		chk_fl(5'b11001, "resume after params");
		// Second reset in mid-run returns everything to the stopped state.
		rst_n_i = 1'b0;
		repeat (3) @(negedge ref_clk_i);
		rst_n_i = 1'b1;
		chk_fl(5'b10000, "second reset");
		chk16(entry, dcr_pkg::ENTRY_RST, "entry after reset");
		wait_stat(dcr_pkg::STAT_STOPPED);
		print_verdict();
	end
endmodule

`default_nettype wire
